// ### tb/mdad_chk_assertions.sv
// Port level checks of the mode dependent address decoder
`timescale 1ns/1ps
`include "mdad_params.svh"
module mdad_chk
    import mdad_pkg::*;
(
    // Clock and reset
    input wire logic         clock,
    input wire logic         rst,
    // Fetch side
    input wire logic         fetch_req,
    input wire logic [31:0]  fetch_base,
    input wire logic [31:0]  fetch_disp,
    input wire logic         irq_ack,
    input wire logic [9:0]   irq_code,
    input wire logic         fetch_valid,
    input wire logic [31:0]  fetch_addr,
    input wire mdad_target_t fetch_target,
    input wire logic [7:0]   fetch_cs,
    // Operand side
    input wire logic         op_done,
    input wire mdad_target_t op_target,
    input wire logic [27:0]  op_addr,
    input wire logic [7:0]   op_cs,
    // Peripheral port and bus width
    input wire logic         periph_req,
    input wire logic [11:0]  periph_addr,
    input wire logic         ext_bus16
);
    logic       booted;
    logic [1:0] run_cnt;
    // Boot fetch has priority, so user fetches are judged only after it
    always_ff @(posedge clock) begin
        if (rst) begin
            booted  <= 1'b0;
            run_cnt <= 2'h0;
        end else begin
            booted  <= booted | fetch_valid;
            run_cnt <= run_cnt + {1'b0, run_cnt != 2'h3};
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    chk_fetch_wrap: assert property (booted && fetch_req && !irq_ack |=> fetch_valid &&
        fetch_addr == (($past(fetch_base) + $past(fetch_disp)) & `MDAD_PC_MASK))
        else $error("fetch address not wrapped to 26 bits");
    chk_irq_vector: assert property (booted && irq_ack |=> fetch_valid &&
        fetch_addr == {18'h0, $past(irq_code), 4'h0}) else $error("bad vector address");
    chk_fetch_noper: assert property (fetch_valid && fetch_addr[25:12] == 14'h3fff
        |-> fetch_target == TGT_FAULT) else $error("fetch served from peripheral image");
    chk_fetch_cs: assert property (fetch_valid |->
        (fetch_target == TGT_EXT) == $onehot(fetch_cs)) else $error("fetch select wrong");
    chk_op_cs: assert property (op_done |->
        (op_target == TGT_EXT) == $onehot(op_cs)) else $error("operand select wrong");
    chk_mode_held: assert property (run_cnt == 2'h3 |-> $stable(ext_bus16))
        else $error("bus width changed while running");
    chk_periph_even: assert property (periph_req |-> !periph_addr[0])
        else $error("odd peripheral address");
    chk_word_split: assert property (periph_req ##1 periph_req |->
        !$past(periph_addr[1]) && periph_addr == $past(periph_addr) + 12'h002)
        else $error("word split order wrong");
    chk_rom_range: assert property (op_done && op_target == TGT_ROM |->
        op_addr < 28'h0040000 || op_addr inside {[28'h0100000:28'h013ffff]})
        else $error("ROM hit outside physical ROM");
    chk_ram_range: assert property (op_done && op_target == TGT_RAM |->
        op_addr inside {[28'hfffc000:28'hfffe7ff]}) else $error("RAM hit outside RAM");
    cover property (periph_req ##1 periph_req);
    cover property (booted && irq_ack);
    cover property (op_done && op_target == TGT_CAN);
endmodule : mdad_chk

bind mdad_decoder mdad_chk mdad_chk_inst (.*);

// ### tb/mdad_periph_model.sv
// Peripheral register file model on the far side of the decoder
`timescale 1ns/1ps
module mdad_periph_model (
    // Clock
    input  wire logic        clock,
    // Register port from the decoder
    input  wire logic        periph_req,
    input  wire logic [11:0] periph_addr,
    // Answer within the request cycle; the decoder samples it at the next edge
    output logic      [15:0] periph_rdata,
    output logic             periph_byte_wide
);
    logic idle_t = 1'b0;
    always_ff @(posedge clock) begin
        idle_t <= ~idle_t;
    end
    always_comb begin
        if (periph_req) begin
            periph_rdata     = {4'hc, periph_addr};
            // upper half of window byte wide
            periph_byte_wide = periph_addr[11];
        end else begin
            // Lines toggle outside the answer cycle so stale data never matches
            periph_rdata     = {16{idle_t}};
            periph_byte_wide = idle_t;
        end
    end
endmodule : mdad_periph_model

// ### tb/tb.sv
// Self-checking bench of the mode dependent address decoder
`timescale 1ns/1ps
module tb
    import mdad_pkg::*;
;
    logic         clock = 1'b0;
    logic         rst = 1'b1;
    logic         op_mode_sel_pin_a = 1'b0;
    logic         op_mode_sel_pin_b = 1'b1;
    logic         op_mode_sel_pin_c = 1'b0;
    mdad_wb_req_t wb_req = '0;
    logic         wb_ack, fetch_valid, op_ready, op_done, op_we, periph_req, periph_we;
    logic [31:0]  wb_dat_o, fetch_addr, op_wdata, op_rdata;
    logic         fetch_req = 1'b0;
    logic [31:0]  fetch_base = 32'h0;
    logic [31:0]  fetch_disp = 32'h0;
    logic         irq_ack = 1'b0;
    logic [9:0]   irq_code = 10'h0;
    mdad_target_t fetch_target, op_target;
    logic [7:0]   fetch_cs, op_cs;
    mdad_op_req_t op_req = '0;
    logic [27:0]  op_addr;
    logic [11:0]  periph_addr;
    logic [15:0]  periph_wdata, periph_rdata;
    logic [1:0]   periph_be;
    logic         periph_byte_wide, ext_bus16;
    logic [4:0]   port_func_ctl;
    logic [35:0]  fq[$], rq[$];
    logic [68:0]  oq[$], o;
    logic [9:0]   r;
    int           err_count = 0, compares = 0, cyc = 0, n = 0;

    mdad_decoder mdad_decoder_inst (.*);
    mdad_periph_model mdad_periph_model_inst (.*);

    always #12.5 clock = ~clock;

    task cmp(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task cmp_fetch;
        cmp({fetch_target, fetch_addr}, fq.size() ? fq.pop_front() : 36'hx);
    endtask : cmp_fetch

    task cmp_op;
        o = oq.size() ? oq.pop_front() : 69'hx;
        cmp({op_target, (o[68] ? op_rdata : {4'h0, op_addr}) & o[63:32]},
            {o[67:64], o[31:0]});
    endtask : cmp_op

    task cmp_reg;
        cmp({4'h0, wb_dat_o}, rq.size() ? rq.pop_front() : 36'hx);
    endtask : cmp_reg

    task stop_test;
        // Notes never retired mean results that never came
        if (fq.size() + oq.size() + rq.size() != 0)
            err_count++;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // Watcher: each result retires the oldest note of its kind
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            stop_test;
        end
        if (!rst && fetch_valid)
            cmp_fetch;
        if (!rst && op_done)
            cmp_op;
        if (!rst && wb_ack && !wb_req.we)
            cmp_reg;
    end

    task boot(input logic [2:0] m, input mdad_target_t t);
        rst <= 1'b1;
        {op_mode_sel_pin_c, op_mode_sel_pin_b, op_mode_sel_pin_a} <= m;
        repeat (4) @(posedge clock);
        fq.push_back({t, 32'h0});
        rst <= 1'b0;
        repeat (4) @(posedge clock);
    endtask : boot

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w)
            rq.push_back({4'h0, d});
        wb_req <= '{1'b1, 1'b1, w, a, 4'hf, d};
        do @(posedge clock); while (!wb_ack);
        wb_req <= '0;
        @(posedge clock);
    endtask : wb

    task fetch(input logic i, input logic [31:0] b, d, input mdad_target_t t,
               input logic [31:0] a);
        fq.push_back({t, a});
        irq_ack <= i;
        irq_code <= b[9:0];
        fetch_req <= !i;
        fetch_base <= b;
        fetch_disp <= d;
        @(posedge clock);
        irq_ack <= 1'b0;
        fetch_req <= 1'b0;
        @(posedge clock);
    endtask : fetch

    task op(input logic [27:0] a, input logic [1:0] sz, input logic s, input mdad_target_t t,
            input logic [31:0] m, v);
        logic [31:0] b;
        logic [3:0]  h;
        b = $urandom;
        h = 4'($urandom);
        oq.push_back({s, t, m, v});
        // only the core issues operands here; no DMA source or destination
        // random image nibble and wrapping sum
        op_req <= '{1'b1, b, {h, a} - b, sz, 1'b0, b};
        do @(posedge clock); while (!op_ready);
        op_req.req <= 1'b0;
        @(posedge clock);
    endtask : op

    task fin;
        n++;
        $display("test %0d finished", n);
    endtask : fin

    initial begin
        void'($urandom(13));
        boot(3'h2, TGT_ROM);
        wb(1'b0, 8'h00, 32'h0);
        wb(1'b0, 8'h14, 32'h0);
        fetch(1'b0, 32'h0, 32'h100000, TGT_FAULT, 32'h100000);
        wb(1'b1, 8'h00, 32'h1f);
        wb(1'b0, 8'h00, 32'h1f);
        fetch(1'b0, 32'h0, 32'h100000, TGT_EXT, 32'h100000);
        fetch(1'b0, 32'h3fffffe, 32'h4, TGT_ROM, 32'h2);
        fetch(1'b0, 32'h3fff000, 32'h10, TGT_FAULT, 32'h3fff010);
        fetch(1'b0, 32'h40000, 32'h0, TGT_ROM_UNDEF, 32'h40000);
        fetch(1'b0, 32'h3000000, 32'h0, TGT_EXT, 32'h3000000);
        r = 10'($urandom);
        fetch(1'b1, {22'h0, r}, 32'h0, TGT_ROM, {18'h0, r, 4'h0});
        fin;
        wb(1'b1, 8'h0c, 32'h8200);
        op(28'h0000010, 2'h2, 1'b0, TGT_ROM, 32'hfffffff, 32'h10);
        op(28'hfffe7ff, 2'h0, 1'b0, TGT_RAM, 32'hfffffff, 32'hfffe7ff);
        op(28'hfffe800, 2'h0, 1'b0, TGT_FAULT, 32'h0, 32'h0);
        op(28'h3ffc010, 2'h2, 1'b0, TGT_RAM, 32'hfffffff, 32'hfffc010);
        op(28'hffff005, 2'h2, 1'b1, TGT_PERI, 32'hffffffff, 32'hc006c004);
        op(28'hffff8a0, 2'h2, 1'b1, TGT_PERI, 32'hffffffff, 32'h00a200a0);
        op(28'h3fff011, 2'h0, 1'b1, TGT_PERI, 32'h0, 32'h0);
        op(28'h5000000, 2'h2, 1'b0, TGT_EXT, 32'hfffffff, 32'h5000000);
        op(28'h0802010, 2'h1, 1'b0, TGT_CAN, 32'h0, 32'h0);
        op(28'h0801000, 2'h1, 1'b0, TGT_PROGIO, 32'h0, 32'h0);
        fin;
        boot(3'h3, TGT_EXT);
        wb(1'b0, 8'h10, 32'h7);
        op(28'h0100010, 2'h2, 1'b0, TGT_ROM, 32'hfffffff, 32'h100010);
        op(28'h0140000, 2'h2, 1'b0, TGT_ROM_UNDEF, 32'h0, 32'h0);
        op(28'h0000100, 2'h2, 1'b0, TGT_EXT, 32'hfffffff, 32'h100);
        fin;
        boot(3'h1, TGT_EXT);
        wb(1'b0, 8'h10, 32'h1);
        wb(1'b0, 8'h00, 32'h1f);
        op(28'h0000010, 2'h2, 1'b0, TGT_EXT, 32'hfffffff, 32'h10);
        fetch(1'b0, 32'h0, 32'h40, TGT_EXT, 32'h40);
        fin;
        boot(3'h0, TGT_EXT);
        wb(1'b0, 8'h10, 32'h4);
        fin;
        repeat (10) @(posedge clock);
        stop_test;
    end
endmodule : tb

// ### verilog/mdad_decoder.sv
// Mode dependent address decoder: boot mode, routing, aliasing, peripheral split
// Notes on behaviour
// - Single-chip 0: port pins, boot internal ROM
// - Single-chip 1: control pins, ROM at 100000H
// - ROMless: control pins, internal ROM disabled
// - ROMless 0 bus 16-bit, ROMless 1 8-bit
// - Address bits 31 to 28 ignored
// - Fetch address wraps in 26 bits
// - No fetch from peripheral window or image
// - Operand address wraps in 32 bits
// - 256 KB ROM decode, rest undefined
// - Acknowledged interrupt jumps to table address
// - RAM decodes to FFFE7FFH, rest faults
// - RAM alias at 3FFC000H reaches same storage
// - Peripheral window and its image decoded
// - Peripheral address bit zero ignored
// - Peripheral word access split, low first
// - Byte register halfword read: upper byte zero
// - Programmable window, CAN slice at x2000H
// - External space ranges depend on mode
// - External fetch only in lowest 64 MB
// - External chip select from area registers
`timescale 1ns/1ps
`include "mdad_params.svh"

module mdad_decoder
    import mdad_pkg::*;
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Operating mode pins
    input  wire logic         op_mode_sel_pin_a,
    input  wire logic         op_mode_sel_pin_b,
    input  wire logic         op_mode_sel_pin_c,
    // Register bus
    input  wire mdad_wb_req_t wb_req,
    output logic              wb_ack,
    output logic [31:0]       wb_dat_o,
    // Instruction fetch side
    input  wire logic         fetch_req,
    input  wire logic [31:0]  fetch_base,
    input  wire logic [31:0]  fetch_disp,
    input  wire logic         irq_ack,
    input  wire logic [9:0]   irq_code,
    output logic              fetch_valid,
    output logic [31:0]       fetch_addr,
    output mdad_target_t      fetch_target,
    output logic [7:0]        fetch_cs,
    // Operand side
    input  wire mdad_op_req_t op_req,
    output logic              op_ready,
    output logic              op_done,
    output mdad_target_t      op_target,
    output logic [27:0]       op_addr,
    output logic [7:0]        op_cs,
    output logic              op_we,
    output logic [31:0]       op_wdata,
    output logic [31:0]       op_rdata,
    // Peripheral register port
    output logic              periph_req,
    output logic [11:0]       periph_addr,
    output logic              periph_we,
    output logic [15:0]       periph_wdata,
    output logic [1:0]        periph_be,
    input  wire logic [15:0]  periph_rdata,
    input  wire logic         periph_byte_wide,
    // Pin function and bus width
    output logic [4:0]        port_func_ctl,
    output logic              ext_bus16
);

    mdad_state_t r;
    mdad_state_t next_r;

    // Routes a 28-bit physical address; images are folded here, not by the caller
    function automatic mdad_target_t decode(input logic [27:0] p, input logic fetch,
                                            input mdad_mode_t m, input logic ctl_ok,
                                            input logic [15:0] ppw);
        mdad_target_t t;
        logic [27:0]  lift;
        t = TGT_FAULT;
        lift = p | `MDAD_IMG_LIFT;
        // primary window and image both reach the peripherals
        if ((p & `MDAD_PERI_MASK) == `MDAD_PERI_BASE ||
            (p & `MDAD_PERI_MASK) == `MDAD_PERI_IMG_BASE) begin
            // fetch from the window or image refused
            t = fetch ? TGT_FAULT : TGT_PERI;
        end else if (ppw[`MDAD_PPW_EN_BIT] && p[27:14] == ppw[13:0]) begin
            // CAN slice, last slice reflects onto peripherals
            if (fetch)
                t = TGT_FAULT;
            else if (p[13:12] == `MDAD_PPW_CAN_SEL)
                t = TGT_CAN;
            else if (p[13:12] == `MDAD_PPW_PERI_SEL)
                t = TGT_PERI;
            else
                t = TGT_PROGIO;
        end else if ((p[27:26] == 2'h3 || p[27:26] == 2'h0) &&
                     lift >= `MDAD_RAM_BASE && lift <= `MDAD_RAM_RSV_END) begin
            // RAM and its alias, reserved tail faults
            t = (lift <= `MDAD_RAM_END) ? TGT_RAM : TGT_FAULT;
        end else if (m == MDAD_SINGLE0 && p < `MDAD_ROM_REGION) begin
            // physical ROM then undefined rest of region
            t = (p < `MDAD_ROM_SIZE) ? TGT_ROM : TGT_ROM_UNDEF;
        end else if (m == MDAD_SINGLE1 && p >= `MDAD_ROM_SC1_BASE &&
                     p <= `MDAD_ROM_SC1_END) begin
            t = (p - `MDAD_ROM_SC1_BASE < `MDAD_ROM_SIZE) ? TGT_ROM : TGT_ROM_UNDEF;
        end else if (p <= `MDAD_EXT_TOP) begin
            // external range, fetch limit, pins in control mode
            if (fetch && p >= `MDAD_FETCH_EXT_LIM)
                t = TGT_FAULT;
            else
                t = ctl_ok ? TGT_EXT : TGT_FAULT;
        end
        return t;
    endfunction : decode

    // One-hot chip select of the 16 MB block; 3-bit nibble per block
    function automatic logic [7:0] chip_sel(input logic [27:0] p, input logic [31:0] a,
                                            input logic [31:0] b);
        logic [31:0] w;
        logic [2:0]  n;
        w = p[27] ? b : a;
        n = w[{p[26:24], 2'h0} +: 3];
        return 8'h01 << n;
    endfunction : chip_sel

    // upper byte of a byte-wide register read as zero
    function automatic logic [15:0] periph_half(input logic [15:0] d, input logic bw);
        logic [15:0] h;
        h = {bw ? 8'h0 : d[15:8], d[7:0]};
        return h;
    endfunction : periph_half

    // Byte lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i])
                m[8*i +: 8] = d[8*i +: 8];
        end
        return m;
    endfunction : merge

    always_comb begin
        logic [31:0] fsum;
        logic [31:0] osum;
        logic [27:0] ph;
        logic [27:0] fph;
        logic        ctl_ok;
        logic        wb_go;
        logic        wb_wr;
        logic [31:0] mw;
        mdad_target_t t;
        fsum = 32'h0;
        wb_go = 1'b0;
        wb_wr = 1'b0;
        mw = 32'h0;
        osum = 32'h0;
        ph = 28'h0;
        fph = 28'h0;
        t = TGT_NONE;
        next_r = r;
        ctl_ok = (r.pfc == `MDAD_PFC_CTRL);

        // Mode pins pass two flops
        next_r.mode_s1 = {op_mode_sel_pin_c, op_mode_sel_pin_b, op_mode_sel_pin_a};
        next_r.mode_s2 = r.mode_s1;

        // first cycle after release takes the mode once
        if (!r.mode_valid) begin
            next_r.mode_valid = 1'b1;
            next_r.boot_pend = 1'b1;
            case (r.mode_s2)
                `MDAD_PINS_ROMLESS0: next_r.mode = MDAD_ROMLESS0;
                `MDAD_PINS_ROMLESS1: next_r.mode = MDAD_ROMLESS1;
                `MDAD_PINS_SINGLE1:  next_r.mode = MDAD_SINGLE1;
                default:             next_r.mode = MDAD_SINGLE0;
            endcase
            next_r.pfc = (next_r.mode == MDAD_SINGLE0) ? `MDAD_PFC_PORT : `MDAD_PFC_CTRL;
            // only ROMless 1 narrows the bus
            next_r.ext_bus16 = (next_r.mode != MDAD_ROMLESS1);
        end

        // Register bus, one wait state, unmapped reads zero
        wb_go = wb_req.cyc && wb_req.stb && !r.wb_ack;
        next_r.wb_ack = wb_go;
        next_r.wb_dat = 32'h0;
        if (wb_go) begin
            case (wb_req.adr)
                `MDAD_REG_PORT_FUNC: next_r.wb_dat = {27'h0, r.pfc};
                `MDAD_REG_CSEL_A:    next_r.wb_dat = r.csel_a;
                `MDAD_REG_CSEL_B:    next_r.wb_dat = r.csel_b;
                `MDAD_REG_PPW_BASE:  next_r.wb_dat = {16'h0, r.ppw};
                `MDAD_REG_STATUS:    next_r.wb_dat = {29'h0, r.ext_bus16, r.mode};
                default:             next_r.wb_dat = 32'h0;
            endcase
        end

        // Write lands on the edge that shows ack, while the master still holds it
        wb_wr = wb_req.cyc && wb_req.stb && wb_req.we && r.wb_ack && r.mode_valid;
        if (wb_wr) begin
            case (wb_req.adr)
                `MDAD_REG_PORT_FUNC: begin
                    mw = merge({27'h0, r.pfc}, wb_req.dat, wb_req.sel);
                    next_r.pfc = mw[4:0];
                end
                `MDAD_REG_CSEL_A:    next_r.csel_a = merge(r.csel_a, wb_req.dat, wb_req.sel);
                `MDAD_REG_CSEL_B:    next_r.csel_b = merge(r.csel_b, wb_req.dat, wb_req.sel);
                `MDAD_REG_PPW_BASE: begin
                    mw = merge({16'h0, r.ppw}, wb_req.dat, wb_req.sel);
                    next_r.ppw = mw[15:0];
                end
                default: ;
            endcase
        end

        // Fetch: boot entry first, then interrupt, then program flow
        next_r.f_valid = 1'b0;
        if (r.mode_valid && (r.boot_pend || irq_ack || fetch_req)) begin
            if (r.boot_pend) begin
                // reset entry, internal or external by mode
                fsum = `MDAD_RESET_ENTRY;
                next_r.boot_pend = 1'b0;
            end else if (irq_ack) begin
                fsum = {22'h0, irq_code} << `MDAD_VEC_SHIFT;
            end else begin
                fsum = fetch_base + fetch_disp;
            end
            next_r.f_addr = fsum & `MDAD_PC_MASK;
            fph = next_r.f_addr[27:0];
            next_r.f_valid = 1'b1;
            next_r.f_tgt = decode(fph, 1'b1, r.mode, ctl_ok, r.ppw);
            next_r.f_cs = (next_r.f_tgt == TGT_EXT) ? chip_sel(fph, r.csel_a, r.csel_b) : 8'h0;
        end

        // Operand access sequencer
        next_r.op_done = 1'b0;
        next_r.pr_req = 1'b0;
        case (r.seq)
            SEQ_IDLE: begin
                if (r.mode_valid && op_req.req) begin
                    osum = op_req.base + op_req.disp;
                    ph = osum[27:0];
                    t = decode(ph, 1'b0, r.mode, ctl_ok, r.ppw);
                    next_r.op_tgt = t;
                    next_r.op_we = op_req.we;
                    next_r.op_wdata = op_req.wdata;
                    next_r.op_rdata = 32'h0;
                    next_r.op_addr = (t == TGT_RAM || t == TGT_PERI) ? (ph | `MDAD_IMG_LIFT) : ph;
                    // chip select only for external space
                    next_r.op_cs = (t == TGT_EXT) ? chip_sel(ph, r.csel_a, r.csel_b) : 8'h0;
                    if (t == TGT_PERI) begin
                        next_r.pr_req = 1'b1;
                        next_r.pr_we = op_req.we;
                        next_r.pr_wdata = op_req.wdata[15:0];
                        if (op_req.size == 2'h2) begin
                            next_r.pr_addr = {ph[11:2], 2'h0};
                            next_r.pr_be = 2'h3;
                            next_r.seq = SEQ_LO;
                        end else begin
                            next_r.pr_addr = {ph[11:1], 1'b0};
                            next_r.pr_be = (op_req.size == 2'h0) ? 2'h1 : 2'h3;
                            next_r.seq = SEQ_ONE;
                        end
                    end else begin
                        next_r.op_done = 1'b1;
                    end
                end
            end
            SEQ_ONE: begin
                // upper byte of a byte-wide register read as zero
                next_r.op_rdata = {16'h0, periph_half(periph_rdata, periph_byte_wide)};
                next_r.op_done = 1'b1;
                next_r.seq = SEQ_IDLE;
            end
            SEQ_LO: begin
                // masked low half; then the high half
                next_r.op_rdata[15:0] = periph_half(periph_rdata, periph_byte_wide);
                next_r.pr_req = 1'b1;
                next_r.pr_addr = r.pr_addr + `MDAD_HALF_STEP;
                next_r.pr_wdata = r.op_wdata[31:16];
                next_r.seq = SEQ_HI;
            end
            SEQ_HI: begin
                // high half masked the same way
                next_r.op_rdata[31:16] = periph_half(periph_rdata, periph_byte_wide);
                next_r.op_done = 1'b1;
                next_r.seq = SEQ_IDLE;
            end
            default: next_r.seq = SEQ_IDLE;
        endcase
        // Ready only while idle, so a split cannot be overrun
        next_r.op_ready = next_r.mode_valid && (next_r.seq == SEQ_IDLE);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            r <= '0;
            r.mode <= MDAD_SINGLE0;
            r.ext_bus16 <= 1'b1;
            r.pfc <= `MDAD_PFC_PORT;
            r.csel_a <= `MDAD_CSEL_RST;
            r.csel_b <= `MDAD_CSEL_RST;
            r.ppw <= `MDAD_PPW_RST;
            r.f_tgt <= TGT_NONE;
            r.op_tgt <= TGT_NONE;
            r.seq <= SEQ_IDLE;
            // Synchroniser keeps running so the pins are settled at release
            r.mode_s1 <= next_r.mode_s1;
            r.mode_s2 <= next_r.mode_s2;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack       = r.wb_ack;
    assign wb_dat_o     = r.wb_dat;
    assign fetch_valid  = r.f_valid;
    assign fetch_addr   = r.f_addr;
    assign fetch_target = r.f_tgt;
    assign fetch_cs     = r.f_cs;
    assign op_ready     = r.op_ready;
    assign op_done      = r.op_done;
    assign op_target    = r.op_tgt;
    assign op_addr      = r.op_addr;
    assign op_cs        = r.op_cs;
    assign op_we        = r.op_we;
    assign op_wdata     = r.op_wdata;
    assign op_rdata     = r.op_rdata;
    assign periph_req   = r.pr_req;
    assign periph_addr  = r.pr_addr;
    assign periph_we    = r.pr_we;
    assign periph_wdata = r.pr_wdata;
    assign periph_be    = r.pr_be;
    assign port_func_ctl = r.pfc;
    assign ext_bus16    = r.ext_bus16;

endmodule : mdad_decoder

// ### verilog/mdad_params.svh
// Constants of the mode dependent address decoder
`ifndef MDAD_PARAMS_SVH
`define MDAD_PARAMS_SVH

// Mode pin codes {pin_c, pin_b, pin_a}
`define MDAD_PINS_ROMLESS0   3'h0
`define MDAD_PINS_ROMLESS1   3'h1
`define MDAD_PINS_SINGLE0    3'h2
`define MDAD_PINS_SINGLE1    3'h3

// Address space
`define MDAD_PC_MASK         32'h03ffffff
`define MDAD_ROM_SIZE        28'h0040000
`define MDAD_ROM_REGION      28'h0100000
`define MDAD_ROM_SC1_BASE    28'h0100000
`define MDAD_ROM_SC1_END     28'h01fffff
`define MDAD_RAM_BASE        28'hfffc000
`define MDAD_RAM_END         28'hfffe7ff
`define MDAD_RAM_RSV_END     28'hfffefff
`define MDAD_IMG_LIFT        28'hc000000
`define MDAD_PERI_MASK       28'hffff000
`define MDAD_PERI_BASE       28'hffff000
`define MDAD_PERI_IMG_BASE   28'h3fff000
`define MDAD_EXT_TOP         28'hfffbfff
`define MDAD_FETCH_EXT_LIM   28'h4000000
`define MDAD_PPW_CAN_SEL     2'h2
`define MDAD_PPW_PERI_SEL    2'h3
`define MDAD_RESET_ENTRY     32'h00000000
`define MDAD_VEC_SHIFT       4
`define MDAD_HALF_STEP       12'h002

// Register byte offsets
`define MDAD_REG_PORT_FUNC   8'h00
`define MDAD_REG_CSEL_A      8'h04
`define MDAD_REG_CSEL_B      8'h08
`define MDAD_REG_PPW_BASE    8'h0c
`define MDAD_REG_STATUS      8'h10

// Reset values and fields
`define MDAD_PFC_PORT        5'h00
`define MDAD_PFC_CTRL        5'h1f
`define MDAD_CSEL_RST        32'h00000000
`define MDAD_PPW_RST         16'h0000
`define MDAD_PPW_EN_BIT      15

`endif

// ### verilog/mdad_pkg.sv
// Types of the mode dependent address decoder
package mdad_pkg;

    typedef enum logic [1:0] {
        MDAD_ROMLESS0,
        MDAD_ROMLESS1,
        MDAD_SINGLE0,
        MDAD_SINGLE1
    } mdad_mode_t;

    typedef enum logic [3:0] {
        TGT_NONE,
        TGT_ROM,
        TGT_ROM_UNDEF,
        TGT_RAM,
        TGT_PERI,
        TGT_PROGIO,
        TGT_CAN,
        TGT_EXT,
        TGT_FAULT
    } mdad_target_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ONE,
        SEQ_LO,
        SEQ_HI
    } mdad_seq_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } mdad_wb_req_t;

    typedef struct packed {
        logic        req;
        logic [31:0] base;
        logic [31:0] disp;
        logic [1:0]  size;
        logic        we;
        logic [31:0] wdata;
    } mdad_op_req_t;

    typedef struct packed {
        logic [2:0]   mode_s1;
        logic [2:0]   mode_s2;
        logic         mode_valid;
        mdad_mode_t   mode;
        logic         ext_bus16;
        logic [4:0]   pfc;
        logic [31:0]  csel_a;
        logic [31:0]  csel_b;
        logic [15:0]  ppw;
        logic         wb_ack;
        logic [31:0]  wb_dat;
        logic         boot_pend;
        logic         f_valid;
        logic [31:0]  f_addr;
        mdad_target_t f_tgt;
        logic [7:0]   f_cs;
        mdad_seq_t    seq;
        logic         op_ready;
        logic         op_done;
        mdad_target_t op_tgt;
        logic [27:0]  op_addr;
        logic [7:0]   op_cs;
        logic         op_we;
        logic [31:0]  op_wdata;
        logic [31:0]  op_rdata;
        logic         pr_req;
        logic [11:0]  pr_addr;
        logic         pr_we;
        logic [15:0]  pr_wdata;
        logic [1:0]   pr_be;
    } mdad_state_t;

endpackage : mdad_pkg
